// ---- hw/tsp_defines.vh ----
// Constants for the timer with shared prescaler.
// Included by the timer top and the prescaler module.
`ifndef TSP_DEFINES_VH
`define TSP_DEFINES_VH

// Register indices and byte addresses
`define TSP_IDX_COUNT 4'h1
`define TSP_IDX_CONFIG 4'h2
`define TSP_IDX_CMD 4'h3
`define TSP_ADDR_COUNT 8'h04
`define TSP_ADDR_CONFIG 8'h08
`define TSP_ADDR_CMD 8'h0C

// Configuration fields
`define TSP_CFG_WIDTH 6
`define TSP_CFG_RESET 6'h3F
`define TSP_BIT_SRC 5
`define TSP_BIT_EDGE 4
`define TSP_BIT_ASSIGN 3
`define TSP_RATIO_HI 2
`define TSP_RATIO_LO 0

// Command fields
`define TSP_BIT_WDT_CLEAR 0

// Reset values
`define TSP_COUNT_RESET 8'h00

// Timing
`define TSP_CLK_PER_INSTR 4
`define TSP_INHIBIT_INSTR 2'h2

`endif

// ---- hw/tsp_prescaler.v ----
// Shared 8-bit prescaler counter with selectable tap and wrap pulse.
// Assumes one clock; step and clear are single-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
`include "tsp_defines.vh"

module tsp_prescaler #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Control
    input wire i_clear,
    input wire i_step,
    input wire [2:0] i_ratio,
    // Result
    output reg o_tap_ff,
    output reg o_wrap_ff
);

    reg [WIDTH-1:0] cnt_ff;
    reg [WIDTH-1:0] nxt_cnt;
    reg [WIDTH-1:0] mask;

    // Low bits that must be zero for a 1:2^ratio wrap
    function [WIDTH-1:0] low_mask;
        input [2:0] r;
        begin
            low_mask = ({WIDTH{1'b1}} << r) ^ {WIDTH{1'b1}};
        end
    endfunction

    always @* begin
        mask = low_mask(i_ratio);
        if (i_clear) begin
            nxt_cnt = {WIDTH{1'b0}};
        end else if (i_step) begin
            nxt_cnt = cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            nxt_cnt = cnt_ff;
        end
    end

    // Tap bit toggles every 2^ratio steps, so its period is symmetrical
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= {WIDTH{1'b0}};
            o_tap_ff <= 1'b0;
            o_wrap_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            o_tap_ff <= nxt_cnt[i_ratio];
            o_wrap_ff <= i_step & ~i_clear & ((nxt_cnt & mask) == {WIDTH{1'b0}});
        end
    end

endmodule
`default_nettype wire

// ---- hw/tsp_timer.v ----
// Notes on behaviour
// - Source select zero: timer mode, one count per instruction cycle without prescaler.
// - A write to the count register blocks counting for two instruction cycles.
// - Source select one: counter mode, counts external input edges.
// - Edge select zero counts rising edges, one counts falling edges.
// - Prescaler serves timer or watchdog, never both; assign bit one gives watchdog.
// - Prescaler is 8 bits, timer ratio 1:2 to 1:256 in powers of two.
// - Assign bit and three ratio bits decide owner and ratio.
// - Software can neither read nor write the prescaler.
// - Counter mode samples prescaler output on phase two and phase four.
// - Assigned prescaler divides external input into a symmetrical output first.
// - Count updates only after the edge has passed the sampling stages.
// - Count register writes clear the prescaler while the timer owns it.
// - Watchdog clear clears the prescaler while the watchdog owns it.
// - Any reset zeroes the prescaler.
// - Assignment may change at any time by rewriting configuration.
// - Count register is 8-bit read/write at index 01h.
//
// Timer/counter top with AHB-Lite register slave.
// Assumes a single AHB-Lite master, inputs synchronous to i_clk_sys,
// and a watchdog that supplies tick and clear pulses.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tsp_defines.vh"

module tsp_timer #(
    parameter COUNT_WIDTH = 8,
    parameter PRESCALE_WIDTH = 8
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // AHB-Lite slave
    input wire i_hsel,
    input wire [7:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    // External count pin
    input wire i_ext_count_input,
    // Watchdog side
    input wire i_wdt_tick,
    input wire i_watchdog_clear_instr,
    output reg o_wdt_clear_ff,
    output reg o_wdt_post_tick_ff,
    // Count wrap
    output reg o_count_wrap_ff
);

    localparam PH_ONE = 4'b0001;
    localparam PH_TWO = 4'b0010;
    localparam PH_THREE = 4'b0100;
    localparam PH_FOUR = 4'b1000;

    reg [3:0] phase_ff;
    reg [3:0] nxt_phase;
    reg [COUNT_WIDTH-1:0] count_ff;
    reg [COUNT_WIDTH-1:0] nxt_count;
    reg [`TSP_CFG_WIDTH-1:0] config_ff;
    reg [1:0] inhibit_ff;
    reg [1:0] nxt_inhibit;
    reg wr_pend_ff;
    reg [3:0] wr_idx_ff;
    reg pin_prev_ff;
    reg samp_ff;
    reg samp_prev_ff;
    reg inc_req_ff;

    wire addr_phase;
    wire [3:0] addr_idx;
    wire phase_one;
    wire phase_two;
    wire phase_four;
    wire src_counter;
    wire edge_fall;
    wire presc_to_wdt;
    wire [2:0] ratio;
    wire sel_level;
    wire sel_edge;
    wire count_write;
    wire cmd_wdt_clear;
    wire wdt_clear_evt;
    wire presc_clear;
    wire presc_step;
    wire presc_tap;
    wire presc_wrap;
    wire sync_out;
    wire direct_tick;
    wire inc_now;

    // Word index of a byte address; register offsets are word indices
    function [3:0] word_index;
        input [7:0] a;
        begin
            word_index = a[5:2];
        end
    endfunction

    assign addr_phase = i_hsel & i_htrans[1] & i_hready;
    assign addr_idx = word_index(i_haddr);

    assign src_counter = config_ff[`TSP_BIT_SRC];
    assign edge_fall = config_ff[`TSP_BIT_EDGE];
    assign presc_to_wdt = config_ff[`TSP_BIT_ASSIGN];
    assign ratio = config_ff[`TSP_RATIO_HI:`TSP_RATIO_LO];

    assign phase_one = phase_ff[0];
    assign phase_two = phase_ff[1];
    assign phase_four = phase_ff[3];

    // Instruction cycle is four clocks, one per internal phase
    always @* begin
        case (phase_ff)
            PH_ONE: begin
                nxt_phase = PH_TWO;
            end
            PH_TWO: begin
                nxt_phase = PH_THREE;
            end
            PH_THREE: begin
                nxt_phase = PH_FOUR;
            end
            PH_FOUR: begin
                nxt_phase = PH_ONE;
            end
            default: begin
                nxt_phase = PH_ONE;
            end
        endcase
    end

    // Pin level turned so the counted edge always looks like a rise
    assign sel_level = i_ext_count_input ^ edge_fall;
    assign sel_edge = sel_level & ~pin_prev_ff;

    // Data-phase write strobes
    assign count_write = wr_pend_ff & (wr_idx_ff == `TSP_IDX_COUNT);
    assign cmd_wdt_clear = wr_pend_ff & (wr_idx_ff == `TSP_IDX_CMD)
        & i_hwdata[`TSP_BIT_WDT_CLEAR];
    assign wdt_clear_evt = cmd_wdt_clear | i_watchdog_clear_instr;

    // Only side effects reach the prescaler, never bus data
    assign presc_clear = (count_write & ~presc_to_wdt)
        | (wdt_clear_evt & presc_to_wdt);

    // Prescaler source follows its owner; owner may change live
    assign presc_step = presc_to_wdt ? i_wdt_tick
        : (src_counter ? sel_edge : phase_four);

    tsp_prescaler #(
        .WIDTH(PRESCALE_WIDTH)
    ) u_prescaler (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_clear(presc_clear),
        .i_step(presc_step),
        .i_ratio(ratio),
        .o_tap_ff(presc_tap),
        .o_wrap_ff(presc_wrap)
    );

    // Without an owned prescaler the output is the edge-selected pin level sel_level
    assign sync_out = presc_to_wdt ? sel_level : presc_tap;

    // Timer mode with no prescaler counts every instruction cycle
    assign direct_tick = ~src_counter & presc_to_wdt & phase_four;

    // Increment requests inside the write inhibit window are dropped
    assign inc_now = inc_req_ff & (inhibit_ff == 2'h0);

    always @* begin
        nxt_count = count_ff;
        nxt_inhibit = inhibit_ff;
        if (count_write) begin
            nxt_count = i_hwdata[COUNT_WIDTH-1:0];
            nxt_inhibit = `TSP_INHIBIT_INSTR;
        end else begin
            // Counted at phase one, so both following increment slots are blocked
            if (phase_one && (inhibit_ff != 2'h0)) begin
                nxt_inhibit = inhibit_ff - 2'h1;
            end
            if (inc_now) begin
                nxt_count = count_ff + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Phase, sampling and count
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            phase_ff <= PH_ONE;
            // High, so a low idle pin under the falling-edge reset config is no edge
            pin_prev_ff <= 1'b1;
            samp_ff <= 1'b1;
            samp_prev_ff <= 1'b1;
            inc_req_ff <= 1'b0;
            inhibit_ff <= 2'h0;
            count_ff <= `TSP_COUNT_RESET;
            o_count_wrap_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            pin_prev_ff <= sel_level;
            // Sampled only on phase two and four, as a level
            if (phase_two || phase_four) begin
                samp_ff <= sync_out;
                samp_prev_ff <= samp_ff;
            end
            // Rise seen after two samples gives the increment request
            if (count_write) begin
                inc_req_ff <= 1'b0;
            end else if (src_counter || !presc_to_wdt) begin
                inc_req_ff <= (phase_two || phase_four) & samp_ff & ~samp_prev_ff;
            end else begin
                inc_req_ff <= direct_tick;
            end
            inhibit_ff <= nxt_inhibit;
            count_ff <= nxt_count;
            o_count_wrap_ff <= ~count_write & inc_now & (count_ff == {COUNT_WIDTH{1'b1}});
        end
    end

    // Watchdog side outputs
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_wdt_clear_ff <= 1'b0;
            o_wdt_post_tick_ff <= 1'b0;
        end else begin
            o_wdt_clear_ff <= wdt_clear_evt;
            // Owned postscaler divides ticks, otherwise ticks pass 1:1
            o_wdt_post_tick_ff <= presc_to_wdt ? presc_wrap : i_wdt_tick;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 4'h0;
            config_ff <= `TSP_CFG_RESET;
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            wr_pend_ff <= addr_phase & i_hwrite;
            if (addr_phase) begin
                wr_idx_ff <= addr_idx;
            end
            // Configuration may be rewritten at any time
            if (wr_pend_ff && (wr_idx_ff == `TSP_IDX_CONFIG)) begin
                config_ff <= i_hwdata[`TSP_CFG_WIDTH-1:0];
            end
            // Only the count register reads back; the rest read zero
            if (addr_phase && !i_hwrite && (addr_idx == `TSP_IDX_COUNT)) begin
                o_hrdata <= {{(32-COUNT_WIDTH){1'b0}}, nxt_count};
            end else begin
                o_hrdata <= 32'h00000000;
            end
        end
    end

endmodule
`default_nettype wire

// ---- test/tsp_ext_src.sv ----
// External count source: toggles the pin a set number of times.
// Each level holds four clocks; the pin stands still between runs.
`timescale 1ns/1ns
`default_nettype none
module tsp_ext_src (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Control
    input wire logic i_start,
    input wire logic [7:0] i_toggles,
    // Pin and status
    output logic o_pin_ff,
    output wire logic o_busy
);
    logic [7:0] left_ff;
    logic [1:0] hold_ff;
    assign o_busy = left_ff != 8'h00 || hold_ff != 2'h0;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pin_ff <= 1'b0;
            left_ff <= 8'h00;
            hold_ff <= 2'h0;
        end else if (i_start) begin
            left_ff <= i_toggles;
        end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
        end else if (left_ff != 8'h00) begin
            o_pin_ff <= ~o_pin_ff;
            left_ff <= left_ff - 8'h01;
            hold_ff <= 2'h3;
        end
    end
endmodule
`default_nettype wire

// ---- test/tsp_chk_properties.sv ----
// Port checker for the timer top.
// Assumes clear pulses and ticks never come back to back.
`timescale 1ns/1ns
`default_nettype none
module tsp_chk #(
    parameter COUNT_WIDTH = 8,
    parameter PRESCALE_WIDTH = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Bus
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // Watchdog and count
    input wire logic i_wdt_tick,
    input wire logic i_watchdog_clear_instr,
    input wire logic o_wdt_clear_ff,
    input wire logic o_wdt_post_tick_ff,
    input wire logic o_count_wrap_ff
);
    logic rd_ff;
    logic cmd_ff;
    wire logic acc = i_hsel && i_htrans[1] && i_hready;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_ff <= 1'b0;
            cmd_ff <= 1'b0;
        end else begin
            rd_ff <= acc && !i_hwrite && i_haddr[5:2] == 4'h1;
            cmd_ff <= acc && i_hwrite && i_haddr[5:2] == 4'h3;
        end
    end
    default clocking dck @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    bus_okay_a: assert property (o_hreadyout && !o_hresp) else $error("bus stall");
    idle_zero_a: assert property (!rd_ff |-> o_hrdata == 32'h0) else $error("rdata leak");
    count_width_a: assert property (rd_ff |-> o_hrdata[31:8] == 24'h0) else $error("wide");
    pin_clear_a: assert property (i_watchdog_clear_instr |=> o_wdt_clear_ff)
        else $error("pin clear lost");
    cmd_clear_a: assert property (cmd_ff && i_hwdata[0] |-> ##[1:2] o_wdt_clear_ff)
        else $error("cmd clear lost");
    clear_once_a: assert property (o_wdt_clear_ff |=> !o_wdt_clear_ff) else $error("clr");
    wrap_gap_a: assert property (o_count_wrap_ff |=> !o_count_wrap_ff [*3])
        else $error("wrap too soon");
    post_cause_a: assert property (o_wdt_post_tick_ff |-> $past(i_wdt_tick) ||
        $past(i_wdt_tick, 2)) else $error("post tick without tick");
    post_once_a: assert property (o_wdt_post_tick_ff |=> !o_wdt_post_tick_ff)
        else $error("post tick long");
    cover property (o_count_wrap_ff);
    cover property (o_wdt_post_tick_ff);
    cover property (o_wdt_clear_ff);
endmodule
bind tsp_timer tsp_chk #(.COUNT_WIDTH(COUNT_WIDTH), .PRESCALE_WIDTH(PRESCALE_WIDTH)) u_tsp_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_wdt_tick(i_wdt_tick), .i_watchdog_clear_instr(i_watchdog_clear_instr),
    .o_wdt_clear_ff(o_wdt_clear_ff), .o_wdt_post_tick_ff(o_wdt_post_tick_ff),
    .o_count_wrap_ff(o_count_wrap_ff));
`default_nettype wire

// ---- test/tb.sv ----
// Bench for the timer: bus tasks, pin source, watchdog ticks.
// Assumes the slave answers OKAY with no fixed wait count.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk, rst, hsel, hwrite, tick, wclr, start;
    logic [1:0] htrans;
    logic [7:0] haddr, togs;
    logic [31:0] hwdata, rd;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, wdclr, post, wrap, pin, busy;
    integer fails = 0, compares = 0, posts = 0, wraps = 0, r;
    always #20 clk = ~clk;
    tsp_timer u_tsp_timer (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_ext_count_input(pin), .i_wdt_tick(tick), .i_watchdog_clear_instr(wclr),
        .o_wdt_clear_ff(wdclr), .o_wdt_post_tick_ff(post), .o_count_wrap_ff(wrap));
    tsp_ext_src u_tsp_ext_src (.i_clk_sys(clk), .i_rst(rst), .i_start(start),
        .i_toggles(togs), .o_pin_ff(pin), .o_busy(busy));
    always @(posedge clk) begin
        if (post === 1'b1) posts = posts + 1;
        if (wrap === 1'b1) wraps = wraps + 1;
    end
    task step;
        begin
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
        end
    endtask
    task xfer(input [7:0] a, input w, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            step;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            step;
            rd = hrdata;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            compares++;
            if (g !== e) begin
                fails++;
                $display("MISMATCH %s exp %0h got %0h", nm, e, g);
            end
        end
    endtask
    task rng(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] g);
        begin
            compares++;
            if ((g >= lo && g <= hi) !== 1'b1) begin
                fails++;
                $display("MISMATCH %s exp %0h..%0h got %0h", nm, lo, hi, g);
            end
        end
    endtask
    task tk(input integer n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task wclear;
        begin
            wclr <= 1'b1;
            @(posedge clk);
            wclr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task run(input [7:0] t);
        begin
            // Let the count write inhibit run out before the first edge
            repeat (12) @(posedge clk);
            start <= 1'b1;
            togs <= t;
            @(posedge clk);
            start <= 1'b0;
            @(posedge clk);
            repeat (200) if (busy === 1'b1) @(posedge clk);
            repeat (10) @(posedge clk);
            xfer(8'h04, 1'b0, 32'h0);
        end
    endtask
    task wrap_up;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        wrap_up;
    end
    initial begin
        {clk, rst, hsel, hwrite, tick, wclr, start} = 7'h20;
        {htrans, haddr, togs, hwdata} = 50'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Long enough for a false edge after reset to reach the count
        repeat (9) @(posedge clk);
        xfer(8'h04, 1'b0, 32'h0);
        chk("count reset", 32'h0, rd);
        xfer(8'h08, 1'b0, 32'h0);
        chk("config read", 32'h0, rd);
        xfer(8'h10, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(8'h08, 1'b1, 32'h08);
        xfer(8'h04, 1'b1, 32'hFC);
        xfer(8'h04, 1'b0, 32'h0);
        chk("inhibit", 32'hFC, rd);
        repeat (40) @(posedge clk);
        xfer(8'h04, 1'b0, 32'h0);
        rng("timer", 32'h4, 32'h5, rd);
        chk("wraps", 32'h1, wraps);
        xfer(8'h08, 1'b1, 32'h28);
        xfer(8'h04, 1'b1, 32'h0);
        run(8'h07);
        chk("rising", 32'h4, rd);
        xfer(8'h08, 1'b1, 32'h38);
        xfer(8'h04, 1'b1, 32'h0);
        run(8'h05);
        chk("falling", 32'h3, rd);
        xfer(8'h08, 1'b1, 32'h3A);
        xfer(8'h0C, 1'b1, 32'h1);
        posts = 0;
        tk(8);
        chk("post 1:4", 32'h2, posts);
        tk(2);
        wclear;
        tk(3);
        chk("post cleared", 32'h2, posts);
        tk(1);
        chk("post after", 32'h3, posts);
        wclear;
        xfer(8'h08, 1'b1, 32'h20);
        xfer(8'h04, 1'b1, 32'h0);
        run(8'h10);
        chk("pin 1:2", 32'h4, rd);
        posts = 0;
        tk(3);
        chk("post 1:1", 32'h3, posts);
        for (r = 0; r < 8; r++) begin
            xfer(8'h08, 1'b1, r);
            xfer(8'h04, 1'b1, 32'h0);
            repeat (64 << (r + 1)) @(posedge clk);
            xfer(8'h04, 1'b0, 32'h0);
            rng("ratio", 32'hE, 32'h11, rd);
        end
        wclear;
        xfer(8'h04, 1'b1, 32'h0);
        xfer(8'h08, 1'b1, 32'h2B);
        wclear;
        posts = 0;
        tk(8);
        chk("post 1:8", 32'h1, posts);
        wrap_up;
    end
endmodule
`default_nettype wire
